/* File: src/ccd_chop_detect.sv */
// chop settle timer, current-detect engine and axi4-lite register bank
// Summary of operation
// - chop enabled: wait settle delay after each transition
// - settle delay code n gives 2^(n+1) periods
// - all-channels bit picks any or all qualifying
// - hit-count code n needs 2^n exceedances
// - detect enable with window length lookup table
// - threshold high word holds threshold bits 23:8
// - threshold low word bits 15:8 hold 7:0
//
// Our own choice: the AXI4-Lite register port.
module ccd_chop_detect #(
  parameter int NUM_CH = 4, // converter channels
  parameter int DATA_W = 24 // conversion result width
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // modulator and conversion timing
  input wire logic i_mod_tick, // one pulse per modulator clock period
  input wire logic i_chop_edge, // pulse at each chop transition
  input wire logic i_conv_valid, // pulse per conversion period
  input wire logic [NUM_CH*DATA_W-1:0] i_conv_data, // channel 0 in low bits
  output logic o_meas_allowed, // measurement may begin
  output logic o_detect, // one-cycle detection pulse
  output logic o_irq, // level interrupt
  // axi4-lite slave
  input wire logic [ccd_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ccd_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  // comparator and threshold are fixed at 24 bits
  if (NUM_CH < 1 || DATA_W != 24) begin : g_bad_param
    $error("ccd_chop_detect: NUM_CH must be >= 1 and DATA_W must be 24");
  end

  // ==========================================================================
  // functions
  // ==========================================================================
  // byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge_strb(input logic [15:0] old_v, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [15:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // word index from byte address, misaligned maps to nothing
  function automatic logic [7:0] addr_index(input logic [ccd_pkg::ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) ? {2'h0, a[ccd_pkg::ADDR_W-1:2]} : 8'hFF;
  endfunction

  // window length in conversion periods
  function automatic logic [ccd_pkg::WIN_CNT_W-1:0] win_len(input logic [2:0] code);
    case (code)
      3'h0: return 12'h080; // 128
      3'h1: return 12'h100; // 256
      3'h2: return 12'h200; // 512
      3'h3: return 12'h300; // 768
      3'h4: return 12'h500; // 1280
      3'h5: return 12'h700; // 1792
      3'h6: return 12'hA00; // 2560
      default: return 12'hE00; // 3584
    endcase
  endfunction

  // ==========================================================================
  // registers
  // ==========================================================================
  logic [15:0] cfg_ff; // chop_and_detect_config
  logic [15:0] thr_high_ff; // current_detect_threshold_high
  logic [7:0] thr_low_ff; // threshold bits 7:0
  logic [3:0] dc_block_ff; // stored, no function here
  logic [ccd_pkg::EV_W-1:0] irq_status_ff; // sticky events
  logic [ccd_pkg::EV_W-1:0] irq_mask_ff; // interrupt enables
  ccd_pkg::ccd_cfg_type cfg; // decoded view

  always_comb begin
    cfg.chop_settle_delay = cfg_ff[ccd_pkg::CFG_CHOP_DLY_LSB +: 4];
    cfg.chop_enable = cfg_ff[ccd_pkg::CFG_CHOP_EN_BIT];
    cfg.detect_all_channels = cfg_ff[ccd_pkg::CFG_ALL_CH_BIT];
    cfg.detect_hit_count = cfg_ff[ccd_pkg::CFG_HIT_CNT_LSB +: 3];
    cfg.detect_window_length = cfg_ff[ccd_pkg::CFG_WIN_LEN_LSB +: 3];
    cfg.detect_mode_enable = cfg_ff[ccd_pkg::CFG_DETECT_EN_BIT];
    cfg.threshold = {thr_high_ff, thr_low_ff};
  end

  // ==========================================================================
  // axi4-lite write channel
  // ==========================================================================
  logic aw_full_ff; // address captured
  logic w_full_ff; // data captured
  logic [ccd_pkg::ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic do_write; // commit cycle
  logic [7:0] wr_idx;
  logic wr_hit;

  // each channel refuses further items until the response has gone
  assign o_awready = !aw_full_ff && !bvalid_ff;
  assign o_wready = !w_full_ff && !bvalid_ff;
  assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;
  assign wr_idx = addr_index(aw_addr_ff);
  assign wr_hit = (wr_idx == ccd_pkg::CFG_IDX) || (wr_idx == ccd_pkg::THR_HIGH_IDX) ||
                  (wr_idx == ccd_pkg::THR_LOW_IDX) || (wr_idx == ccd_pkg::IRQ_STATUS_IDX) ||
                  (wr_idx == ccd_pkg::IRQ_MASK_IDX) || (wr_idx == ccd_pkg::DET_STATUS_IDX);
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;

  // address holding stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (i_awvalid && o_awready) begin
      aw_full_ff <= 1'b1;
      aw_addr_ff <= i_awaddr;
    end else if (do_write) begin
      aw_full_ff <= 1'b0;
    end
  end

  // data holding stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      w_full_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      w_full_ff <= 1'b1;
      w_data_ff <= i_wdata;
      w_strb_ff <= i_wstrb;
    end else if (do_write) begin
      w_full_ff <= 1'b0;
    end
  end

  // response, slverr for unmapped or misaligned addresses
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= ccd_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? ccd_pkg::RESP_OKAY : ccd_pkg::RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // configuration word, reserved top bits kept as written
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_ff <= ccd_pkg::CFG_RESET; // chop off, delay code 0011
    end else if (do_write && wr_idx == ccd_pkg::CFG_IDX) begin
      cfg_ff <= merge_strb(cfg_ff, w_data_ff, w_strb_ff);
    end
  end

  // threshold high word
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      thr_high_ff <= ccd_pkg::THR_HIGH_RESET;
    end else if (do_write && wr_idx == ccd_pkg::THR_HIGH_IDX) begin
      thr_high_ff <= merge_strb(thr_high_ff, w_data_ff, w_strb_ff);
    end
  end

  // threshold low word, bits 7:4 are read-only zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      thr_low_ff <= ccd_pkg::THR_LOW_RESET[15:8];
      dc_block_ff <= ccd_pkg::THR_LOW_RESET[3:0];
    end else if (do_write && wr_idx == ccd_pkg::THR_LOW_IDX) begin
      if (w_strb_ff[1]) begin
        thr_low_ff <= w_data_ff[ccd_pkg::THR_LOW_LSB +: 8];
      end
      if (w_strb_ff[0]) begin
        dc_block_ff <= w_data_ff[ccd_pkg::DC_BLOCK_LSB +: 4];
      end
    end
  end

  // interrupt mask
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_mask_ff <= ccd_pkg::IRQ_MASK_RESET;
    end else if (do_write && wr_idx == ccd_pkg::IRQ_MASK_IDX && w_strb_ff[0]) begin
      irq_mask_ff <= w_data_ff[ccd_pkg::EV_W-1:0];
    end
  end

  // ==========================================================================
  // chop settle timer
  // ==========================================================================
  logic [ccd_pkg::CHOP_CNT_W-1:0] chop_cnt_ff; // modulator periods left
  logic settle_done; // last period counted

  assign settle_done = cfg.chop_enable && i_mod_tick && !i_chop_edge &&
                       (chop_cnt_ff == ccd_pkg::CHOP_CNT_W'(1));
  // measurement held off while the settle count runs
  assign o_meas_allowed = !cfg.chop_enable || (chop_cnt_ff == '0);

  // a new transition restarts the count even mid-settle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      chop_cnt_ff <= '0;
    end else if (!cfg.chop_enable) begin
      chop_cnt_ff <= '0;
    end else if (i_chop_edge) begin
      chop_cnt_ff <= ccd_pkg::CHOP_CNT_W'(2) << cfg.chop_settle_delay;
    end else if (i_mod_tick && chop_cnt_ff != '0) begin
      chop_cnt_ff <= chop_cnt_ff - ccd_pkg::CHOP_CNT_W'(1);
    end
  end

  // ==========================================================================
  // current-detect comparators
  // ==========================================================================
  logic [NUM_CH-1:0] ch_over; // channel magnitude above threshold
  logic conv_hit; // this conversion qualifies

  // magnitude of the signed result, so both current directions count
  for (genvar g = 0; g < NUM_CH; g++) begin : g_cmp
    logic [DATA_W-1:0] raw;
    logic [DATA_W-1:0] mag;
    assign raw = i_conv_data[g*DATA_W +: DATA_W];
    assign mag = raw[DATA_W-1] ? (~raw + DATA_W'(1)) : raw;
    assign ch_over[g] = (mag > cfg.threshold);
  end

  assign conv_hit = cfg.detect_all_channels ? (&ch_over) : (|ch_over);

  // ==========================================================================
  // current-detect sequencer
  // ==========================================================================
  ccd_pkg::ccd_det_state_type state_ff;
  ccd_pkg::ccd_det_state_type nxt_state;
  logic [ccd_pkg::WIN_CNT_W-1:0] win_cnt_ff; // conversions in window
  logic [ccd_pkg::HIT_CNT_W-1:0] hit_cnt_ff; // exceedances in window
  logic [ccd_pkg::HIT_CNT_W-1:0] hit_need; // exceedances required
  logic sample; // a conversion counted now
  logic win_last; // final conversion of the window
  logic hit_reached; // requirement met now
  logic win_miss; // window closed without detection

  assign hit_need = ccd_pkg::HIT_CNT_W'(1) << cfg.detect_hit_count;
  assign sample = (state_ff == ccd_pkg::DET_MEASURE) && i_conv_valid && o_meas_allowed;
  // at-or-beyond compares, so shortening a field mid-window cannot strand the counters
  assign win_last = sample && (win_cnt_ff >= win_len(cfg.detect_window_length) - 12'h001);
  assign hit_reached = sample && conv_hit &&
                       (hit_cnt_ff >= hit_need - ccd_pkg::HIT_CNT_W'(1));
  assign win_miss = win_last && !hit_reached;

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ccd_pkg::DET_IDLE: begin
        if (cfg.detect_mode_enable) begin
          nxt_state = ccd_pkg::DET_MEASURE;
        end
      end
      ccd_pkg::DET_MEASURE: begin
        if (!cfg.detect_mode_enable) begin
          nxt_state = ccd_pkg::DET_IDLE;
        end else if (hit_reached) begin
          nxt_state = ccd_pkg::DET_REPORT;
        end
      end
      ccd_pkg::DET_REPORT: begin
        // one cycle to flag, then a fresh window
        nxt_state = cfg.detect_mode_enable ? ccd_pkg::DET_MEASURE : ccd_pkg::DET_IDLE;
      end
      default: begin
        nxt_state = ccd_pkg::DET_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ccd_pkg::DET_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // window and hit counters, both cleared when a window ends
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      win_cnt_ff <= '0;
      hit_cnt_ff <= '0;
    end else if (state_ff != ccd_pkg::DET_MEASURE || win_last || hit_reached) begin
      win_cnt_ff <= '0;
      hit_cnt_ff <= '0;
    end else if (sample) begin
      win_cnt_ff <= win_cnt_ff + 12'h001;
      if (conv_hit) begin
        hit_cnt_ff <= hit_cnt_ff + ccd_pkg::HIT_CNT_W'(1);
      end
    end
  end

  // detection pulse from a flip-flop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_detect <= 1'b0;
    end else begin
      o_detect <= hit_reached;
    end
  end

  // ==========================================================================
  // interrupt status, set wins over write-one-to-clear
  // ==========================================================================
  logic [ccd_pkg::EV_W-1:0] ev_set;
  logic [ccd_pkg::EV_W-1:0] ev_clr;

  always_comb begin
    ev_set = '0;
    ev_set[ccd_pkg::EV_DETECT_BIT] = hit_reached;
    ev_set[ccd_pkg::EV_SETTLED_BIT] = settle_done;
    ev_set[ccd_pkg::EV_WIN_END_BIT] = win_miss;
    ev_clr = '0;
    if (do_write && wr_idx == ccd_pkg::IRQ_STATUS_IDX && w_strb_ff[0]) begin
      ev_clr = w_data_ff[ccd_pkg::EV_W-1:0];
    end
  end

  // sticky flags
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_status_ff <= '0;
    end else begin
      irq_status_ff <= (irq_status_ff & ~ev_clr) | ev_set;
    end
  end

  assign o_irq = |(irq_status_ff & irq_mask_ff);

  // ==========================================================================
  // axi4-lite read channel
  // ==========================================================================
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [7:0] rd_idx;
  logic [31:0] rd_word;
  logic rd_hit;

  assign o_arready = !rvalid_ff;
  assign rd_idx = addr_index(i_araddr);
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;

  // read multiplexer, unused upper bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (rd_idx)
      ccd_pkg::CFG_IDX: rd_word[15:0] = cfg_ff;
      ccd_pkg::THR_HIGH_IDX: rd_word[15:0] = thr_high_ff;
      ccd_pkg::THR_LOW_IDX: rd_word[15:0] = {thr_low_ff, 4'h0, dc_block_ff};
      ccd_pkg::IRQ_STATUS_IDX: rd_word[ccd_pkg::EV_W-1:0] = irq_status_ff;
      ccd_pkg::IRQ_MASK_IDX: rd_word[ccd_pkg::EV_W-1:0] = irq_mask_ff;
      ccd_pkg::DET_STATUS_IDX: rd_word = {16'h0000, hit_cnt_ff, 3'h0, o_meas_allowed, 2'h0, state_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  // read data registered, one cycle after the address is taken
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= ccd_pkg::RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_hit ? ccd_pkg::RESP_OKAY : ccd_pkg::RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

/* File: src/ccd_pkg.sv */
// package with register map, field layout and types of the chop and current-detect configuration block
package ccd_pkg;

  // ==========================================================================
  // register indices, byte address is four times the index
  // ==========================================================================
  localparam logic [7:0] CFG_IDX = 8'h06; // chop_and_detect_config
  localparam logic [7:0] THR_HIGH_IDX = 8'h07; // current_detect_threshold_high
  localparam logic [7:0] THR_LOW_IDX = 8'h08; // current_detect_threshold_low
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h10; // sticky event flags
  localparam logic [7:0] IRQ_MASK_IDX = 8'h11; // interrupt mask
  localparam logic [7:0] DET_STATUS_IDX = 8'h12; // live detector state
  localparam int ADDR_W = 8; // byte address width on the bus

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int CFG_DETECT_EN_BIT = 0;
  localparam int CFG_WIN_LEN_LSB = 1; // 3 bits
  localparam int CFG_HIT_CNT_LSB = 4; // 3 bits
  localparam int CFG_ALL_CH_BIT = 7;
  localparam int CFG_CHOP_EN_BIT = 8;
  localparam int CFG_CHOP_DLY_LSB = 9; // 4 bits
  localparam int CFG_RSVD_LSB = 13; // 3 bits, stored
  localparam int THR_LOW_LSB = 8; // threshold bits 7:0 live here
  localparam int DC_BLOCK_LSB = 0; // 4 bits, stored only
  localparam int EV_DETECT_BIT = 0; // detection event
  localparam int EV_SETTLED_BIT = 1; // chop settle complete event
  localparam int EV_WIN_END_BIT = 2; // window closed without detection
  localparam int EV_W = 3;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [15:0] CFG_RESET = 16'h0600;
  localparam logic [15:0] THR_HIGH_RESET = 16'h0000;
  localparam logic [15:0] THR_LOW_RESET = 16'h0000;
  localparam logic [EV_W-1:0] IRQ_MASK_RESET = 3'h0;

  // ==========================================================================
  // counter widths and bus answers
  // ==========================================================================
  localparam int CHOP_CNT_W = 17; // holds 65536
  localparam int WIN_CNT_W = 12; // holds 3584
  localparam int HIT_CNT_W = 8; // holds 128
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // decoded configuration carried to the datapath
  typedef struct packed {
    logic [3:0] chop_settle_delay;
    logic chop_enable;
    logic detect_all_channels;
    logic [2:0] detect_hit_count;
    logic [2:0] detect_window_length;
    logic detect_mode_enable;
    logic [23:0] threshold;
  } ccd_cfg_type;

  // detector states, gray along idle -> measure -> report
  typedef enum logic [1:0] {
    DET_IDLE = 2'h0,
    DET_MEASURE = 2'h1,
    DET_REPORT = 2'h3
  } ccd_det_state_type;

endpackage

/* File: test/ccd_chop_detect_monitor.sv */
// checker of bus handshakes, settle gating and detect pulse timing
module ccd_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_mod_tick,
  input wire logic i_chop_edge,
  input wire logic i_conv_valid,
  input wire logic o_meas_allowed,
  input wire logic o_detect,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready
);
  // ==========================================================================
  // clocking, one domain only
  // ==========================================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // both write channels taken at one edge
  sequence s_wr_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  // commit edge first, answer on the edge after
  sequence s_wr_answer;
    !o_bvalid ##1 o_bvalid;
  endsequence
  property p_wr_answer; s_wr_take |=> s_wr_answer; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer not on second edge");
  property p_b_hold; o_bvalid && !i_bready |=> o_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_b_refuse; o_bvalid |-> !o_awready && !o_wready; endproperty
  a_b_refuse: assert property (p_b_refuse) else $error("new write accepted during answer");
  property p_rd_answer; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  // data must not move while the master has not taken it
  property p_r_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data changed while held");
  property p_meas_fall; $fell(o_meas_allowed) |-> $past(i_chop_edge); endproperty
  a_meas_fall: assert property (p_meas_fall) else $error("gate closed without chop edge");
  // a rise comes from the last tick or from a config write committing
  property p_meas_rise; $rose(o_meas_allowed) |-> $past(i_mod_tick) || o_bvalid; endproperty
  a_meas_rise: assert property (p_meas_rise) else $error("gate opened without tick");
  property p_det_cause;
    o_detect |-> ($past(i_conv_valid) && $past(o_meas_allowed)) || $past(i_conv_valid, 2);
  endproperty
  a_det_cause: assert property (p_det_cause) else $error("detect without conversion");
  property p_det_pulse; o_detect |=> !o_detect; endproperty
  a_det_pulse: assert property (p_det_pulse) else $error("detect longer than one cycle");
endmodule
bind ccd_chop_detect ccd_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_mod_tick(i_mod_tick),
  .i_chop_edge(i_chop_edge), .i_conv_valid(i_conv_valid), .o_meas_allowed(o_meas_allowed),
  .o_detect(o_detect), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid),
  .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_rready(i_rready));

/* File: test/tb.sv */
// self-checking bench for the chop and current-detect register block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // row: address, write data, readback, answer code
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } ccd_row_type;
  localparam logic [7:0] A_CFG = 8'h18;
  localparam logic [7:0] A_THH = 8'h1C;
  localparam logic [7:0] A_THL = 8'h20;
  localparam logic [7:0] A_ST = 8'h40;
  localparam logic [7:0] A_MK = 8'h44;
  logic i_clk, i_rst, i_mod_tick, i_chop_edge, i_conv_valid;
  logic [95:0] i_conv_data;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rdat;
  logic [3:0] i_wstrb;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, det;
  logic o_meas_allowed, o_detect, o_irq, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, rsp;
  int miscompares = 0;
  int num_checks = 0;
  // unmapped and misaligned rows must be refused and leave nothing behind
  ccd_row_type rows [6] = '{'{A_CFG, 32'h0000FFFF, 32'h0000FFFF, ccd_pkg::RESP_OKAY},
    '{A_THH, 32'h1234A5C3, 32'h0000A5C3, ccd_pkg::RESP_OKAY},
    '{A_THL, 32'h0000FFFF, 32'h0000FF0F, ccd_pkg::RESP_OKAY},
    '{8'h0C, 32'h00000001, 32'h00000000, ccd_pkg::RESP_SLVERR},
    '{8'h19, 32'h00000001, 32'h00000000, ccd_pkg::RESP_SLVERR},
    '{A_CFG, 32'h00000000, 32'h00000000, ccd_pkg::RESP_OKAY}};

  ccd_chop_detect #(.NUM_CH(4), .DATA_W(24)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_mod_tick(i_mod_tick),
    .i_chop_edge(i_chop_edge), .i_conv_valid(i_conv_valid), .i_conv_data(i_conv_data),
    .o_meas_allowed(o_meas_allowed), .o_detect(o_detect), .o_irq(o_irq), .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready));

  // ==========================================================================
  // helpers
  // ==========================================================================
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // write: each channel released on its own taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge i_clk);
      if (!ta && o_awready === 1'b1) begin
        ta = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (!tw && o_wready === 1'b1) begin
        tw = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (o_bvalid !== 1'b1);
    rsp = o_bresp;
    i_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    do @(posedge i_clk); while (o_rvalid !== 1'b1);
    rdat = o_rdata;
    rsp = o_rresp;
    i_rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  // one conversion; detect may show on either of the next two cycles
  task automatic conv(input logic [95:0] d, input logic exp);
    @(posedge i_clk);
    i_conv_valid <= 1'b1;
    i_conv_data <= d;
    @(posedge i_clk);
    i_conv_valid <= 1'b0;
    i_conv_data <= ~d;
    #1 det = o_detect;
    @(posedge i_clk);
    #1 det = det | o_detect;
    chk(32'(det), 32'(exp));
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    {i_rst, i_mod_tick, i_chop_edge, i_conv_valid, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 9'h100;
    {i_conv_data, i_awaddr, i_araddr, i_wdata} = '0;
    i_wstrb = 4'hF;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk(32'(o_meas_allowed), 32'h1);
    rdchk(A_CFG, {16'h0, ccd_pkg::CFG_RESET});
    rdchk(A_THH, 32'h0);
    rdchk(A_THL, 32'h0);
    rdchk(A_MK, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].a, rows[i].d);
      chk(32'(rsp), 32'(rows[i].r));
      rd(rows[i].a);
      chk(rdat, rows[i].e);
      chk(32'(rsp), 32'(rows[i].r));
    end
    // settle delay for the first codes, ticks spaced two cycles apart
    for (int c = 0; c < 4; c++) begin
      wr(A_CFG, 32'h0100 | (32'(c) << 9));
      @(posedge i_clk);
      i_chop_edge <= 1'b1;
      @(posedge i_clk);
      i_chop_edge <= 1'b0;
      #1 chk(32'(o_meas_allowed), 32'h0);
      for (int k = 1; k <= (2 << c); k++) begin
        @(posedge i_clk);
        i_mod_tick <= 1'b1;
        @(posedge i_clk);
        i_mod_tick <= 1'b0;
        #1 chk(32'(o_meas_allowed), 32'(k == (2 << c)));
      end
    end
    rdchk(A_ST, 32'h2);
    chk(32'(o_irq), 32'h0);
    wr(A_MK, 32'h2);
    #1 chk(32'(o_irq), 32'h1);
    wr(A_ST, 32'h2);
    #1 chk(32'(o_irq), 32'h0);
    // window codes 0 and 1 close after exactly 128 and 256 conversions
    for (int w = 0; w < 2; w++) begin
      wr(A_CFG, 32'h0000);
      wr(A_ST, 32'h7);
      wr(A_CFG, 32'(2 * w + 1));
      for (int n = 0; n < (128 << w) - 1; n++) conv('0, 1'b0);
      rdchk(A_ST, 32'h0);
      conv('0, 1'b0);
      rdchk(A_ST, 32'h4);
    end
    // threshold 0x000100, any channel with two hits, then all channels and any channel with one hit
    wr(A_THH, 32'h0001);
    wr(A_THL, 32'h0000);
    wr(A_CFG, 32'h0000);
    wr(A_ST, 32'h7);
    wr(A_MK, 32'h1);
    wr(A_CFG, 32'h0011);
    conv(96'h000200, 1'b0);
    conv(96'h000200, 1'b1);
    chk(32'(o_irq), 32'h1);
    wr(A_CFG, 32'h0081);
    conv(96'h000200, 1'b0);
    conv({24'hFFFE00, 24'h000300, 24'h7FFFFF, 24'h000101}, 1'b1);
    conv({24'h000200, 24'h000200, 24'h000200, 24'h000100}, 1'b0);
    wr(A_CFG, 32'h0001);
    conv(96'hFFFF00, 1'b0);
    conv({24'hFFFEFF, 72'h0}, 1'b1);
    // reset in mid-run brings the defaults back
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk(32'(o_irq), 32'h0);
    rdchk(A_CFG, {16'h0, ccd_pkg::CFG_RESET});
    rdchk(A_THH, 32'h0);
    finish_test();
  end
  // run needs about 1500 cycles; a hang is cut off well beyond that
  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    finish_test();
  end
endmodule
